// [rtl/esr_pkg.sv]
// Package for the edge-sense and revision register bank.
// Holds offsets, field positions, reset values and bus response codes.
package esr_pkg;

    // Register byte offsets
    localparam logic [7:0] ESR_OFS_CONTROL = 8'h00;
    localparam logic [7:0] ESR_OFS_SENSE = 8'h08;
    localparam logic [7:0] ESR_OFS_REVISION = 8'h0C;

    // Field positions
    localparam int ESR_ENABLE_BIT = 0;
    localparam int ESR_SENSE_BIT = 0;
    localparam int ESR_MAJOR_LSB = 24;
    localparam int ESR_MINOR_LSB = 16;
    localparam int ESR_BUILD_LSB = 0;

    // Reset values
    localparam logic ESR_ENABLE_RST = 1'b0;

    // Bus widths
    localparam int ESR_ADDR_W = 8;
    localparam int ESR_DATA_W = 32;

    // Response codes
    localparam logic [1:0] ESR_RESP_OKAY = 2'h0;
    localparam logic [1:0] ESR_RESP_DECERR = 2'h3;

    // Bus handshake states, Gray coded along idle -> respond
    typedef enum logic [1:0] {
        ESR_IDLE = 2'b00,
        ESR_WR_RESP = 2'b01,
        ESR_RD_RESP = 2'b10
    } esr_state_e;

endpackage

// [rtl/esr_reg_if.sv]
// Interface between the bus front end and the register store.
// Assumes one clock; all strobes are single-cycle.
`timescale 1ns/1ps
`default_nettype none
interface esr_reg_if;
    import esr_pkg::*;
    logic wr_en;
    logic [ESR_ADDR_W-1:0] wr_addr;
    logic [ESR_DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [ESR_ADDR_W-1:0] rd_addr;
    logic [ESR_DATA_W-1:0] rd_data;
    logic rd_hit;

    modport front (output wr_en, output wr_addr, output wr_data,
                   output wr_strb, output rd_addr,
                   input wr_hit, input rd_data, input rd_hit);
    modport store (input wr_en, input wr_addr, input wr_data,
                   input wr_strb, input rd_addr,
                   output wr_hit, output rd_data, output rd_hit);
endinterface
`default_nettype wire

// [rtl/esr_store.sv]
// Register store: control enable, input sense and revision word.
// Assumes the front end presents writes as single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module esr_store #(
    parameter logic DEFAULT_SENSE = 1'b1,
    parameter logic [7:0] REV_MAJOR = 8'h01,
    parameter logic [7:0] REV_MINOR = 8'h00,
    parameter logic [15:0] REV_BUILD = 16'h0000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    esr_reg_if.store rif,
    output logic enable_o,
    output logic sense_o
);
    import esr_pkg::*;

    logic enable_q, enable_d;
    logic sense_q, sense_d;
    logic [ESR_DATA_W-1:0] rev_word;

    // Decode of a register offset into a known register
    function automatic logic is_mapped(input logic [ESR_ADDR_W-1:0] a);
        is_mapped = (a == ESR_OFS_CONTROL) || (a == ESR_OFS_SENSE) ||
                    (a == ESR_OFS_REVISION);
    endfunction

    // Revision word assembly, constant so writes cannot alter it
    assign rev_word = (ESR_DATA_W'(REV_MAJOR) << ESR_MAJOR_LSB) | // R04 R05
                      (ESR_DATA_W'(REV_MINOR) << ESR_MINOR_LSB) | // R06
                      (ESR_DATA_W'(REV_BUILD) << ESR_BUILD_LSB); // R07

    // Next values of control and sense bits; only lane 0 carries them
    always_comb begin
        enable_d = enable_q;
        sense_d = sense_q;
        if (rif.wr_en && rif.wr_strb[0]) begin
            if (rif.wr_addr == ESR_OFS_CONTROL) begin
                enable_d = rif.wr_data[ESR_ENABLE_BIT]; // R08
            end
            if (rif.wr_addr == ESR_OFS_SENSE) begin
                sense_d = rif.wr_data[ESR_SENSE_BIT]; // R01
            end
        end
    end

    // Register the bits; reset sense from the build parameter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            enable_q <= ESR_ENABLE_RST; // R08
            sense_q <= DEFAULT_SENSE; // R03
        end else if (ce_i) begin
            enable_q <= enable_d;
            sense_q <= sense_d;
        end
    end

    // Read mux; unused bits read as zero
    always_comb begin
        rif.rd_data = '0;
        case (rif.rd_addr)
            ESR_OFS_CONTROL: rif.rd_data[ESR_ENABLE_BIT] = enable_q;
            ESR_OFS_SENSE: rif.rd_data[ESR_SENSE_BIT] = sense_q; // R09
            ESR_OFS_REVISION: rif.rd_data = rev_word; // R04
            default: rif.rd_data = '0;
        endcase
    end

    assign rif.rd_hit = is_mapped(rif.rd_addr);
    assign rif.wr_hit = is_mapped(rif.wr_addr);
    assign enable_o = enable_q;
    assign sense_o = sense_q;
endmodule // esr_store
`default_nettype wire

// [rtl/esr_top.sv]
// Edge-sense and revision register bank with an AXI4-Lite slave port.
// Assumes one system clock; event_i is asynchronous to it.
//
// Functional notes
// R01: Sense bit one active high, zero active low
// R02: Software changes sense only while disabled; the bank does not lock it and takes sense writes while enabled too
// R03: Sense resets to build-time default parameter
// R04: Revision is read-only 32-bit word
// R05: Major revision in bits 31 to 24
// R06: Minor revision in bits 23 to 16
// R07: Build number in bits 15 to 0
// R08: Enable is control bit 0, cleared at reset
// R09: Unused sense bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module esr_top #(
    parameter logic DEFAULT_SENSE = 1'b1,
    parameter logic [7:0] REV_MAJOR = 8'h01,
    parameter logic [7:0] REV_MINOR = 8'h00,
    parameter logic [15:0] REV_BUILD = 16'h0000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Write address and data channels
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [esr_pkg::ESR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [esr_pkg::ESR_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // Write response channel
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read channels
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [esr_pkg::ESR_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [esr_pkg::ESR_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Event input and block controls
    input wire logic event_i,
    output logic enable_o,
    output logic sense_o,
    output logic event_active_o
);
    import esr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Address map and access summary
    ////////////////////////////////////////////////////////////////////
    // Offset 0x00: control, bit 0 is the timestamper enable (RW)
    // Offset 0x08: input sense, bit 0 picks the active level (RW)
    // Offset 0x0C: revision word, major, minor and build (RO)
    // Any other offset answers with a decode error and changes nothing.
    // Unused bits of every register read as zero and drop writes.
    // Only byte lane 0 carries writable bits, so wstrb[0] gates them.
    //
    // Handshake timing:
    // A write is taken when both address and data are valid in idle.
    // A read is taken in idle only if no write pair is waiting.
    // The reply valid rises right after the taking edge and stands
    // until the master's ready is sampled high; the next request may
    // then be taken in the following cycle.
    //
    // Sense hazard:
    // The sense bit feeds the event path directly, so flipping it while
    // capture runs makes a false edge. The bank does not lock the bit;
    // software keeps it unchanged while the enable is set.

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks
    ////////////////////////////////////////////////////////////////////
    // The revision fields must tile one 32-bit word without overlap
    if (ESR_DATA_W != 32) begin : g_bad_data_w
        $error("esr_top: data width must be 32");
    end
    if (ESR_MAJOR_LSB != ESR_MINOR_LSB + 8) begin : g_bad_major
        $error("esr_top: major field must sit just above minor");
    end
    if (ESR_MINOR_LSB != ESR_BUILD_LSB + 16) begin : g_bad_minor
        $error("esr_top: minor field must sit just above build");
    end
    // The map needs offsets up to 0x0C
    if (ESR_ADDR_W < 4) begin : g_bad_addr_w
        $error("esr_top: address too narrow for the map");
    end

    ////////////////////////////////////////////////////////////////////
    // Register store
    ////////////////////////////////////////////////////////////////////
    esr_reg_if rif ();

    esr_store #(
        .DEFAULT_SENSE(DEFAULT_SENSE),
        .REV_MAJOR(REV_MAJOR),
        .REV_MINOR(REV_MINOR),
        .REV_BUILD(REV_BUILD)
    ) u_store (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .rif(rif),
        .enable_o(enable_o),
        .sense_o(sense_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus handshake
    ////////////////////////////////////////////////////////////////////
    esr_state_e state_q, state_d;
    logic [1:0] bresp_q, bresp_d;
    logic [1:0] rresp_q, rresp_d;
    logic [ESR_DATA_W-1:0] rdata_q, rdata_d;
    logic wr_take, rd_take;

    // Writes take priority over reads when both arrive in idle
    assign wr_take = ce_i && (state_q == ESR_IDLE) &&
                     s_axi_awvalid && s_axi_wvalid;
    assign rd_take = ce_i && (state_q == ESR_IDLE) &&
                     s_axi_arvalid && !(s_axi_awvalid && s_axi_wvalid);

    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = rd_take;

    // Store-side strobes
    assign rif.wr_en = wr_take;
    assign rif.wr_addr = s_axi_awaddr;
    assign rif.wr_data = s_axi_wdata;
    assign rif.wr_strb = s_axi_wstrb;
    assign rif.rd_addr = s_axi_araddr;

    // Next state and captured response
    always_comb begin
        state_d = state_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        case (state_q)
            ESR_IDLE: begin
                if (wr_take) begin
                    state_d = ESR_WR_RESP;
                    bresp_d = rif.wr_hit ? ESR_RESP_OKAY : ESR_RESP_DECERR;
                end else if (rd_take) begin
                    state_d = ESR_RD_RESP;
                    rdata_d = rif.rd_data;
                    rresp_d = rif.rd_hit ? ESR_RESP_OKAY : ESR_RESP_DECERR;
                end
            end
            ESR_WR_RESP: begin
                if (s_axi_bready) begin
                    state_d = ESR_IDLE;
                end
            end
            ESR_RD_RESP: begin
                if (s_axi_rready) begin
                    state_d = ESR_IDLE;
                end
            end
            default: state_d = ESR_IDLE;
        endcase
    end

    // Handshake registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ESR_IDLE;
            bresp_q <= ESR_RESP_OKAY;
            rresp_q <= ESR_RESP_OKAY;
            rdata_q <= '0;
        end else if (ce_i) begin
            state_q <= state_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_bvalid = (state_q == ESR_WR_RESP);
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = (state_q == ESR_RD_RESP);
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // Event input sense
    ////////////////////////////////////////////////////////////////////
    logic evt_meta_q, evt_sync_q, act_q;
    logic evt_meta_d, evt_sync_d, act_d;

    // Two-stage synchroniser, then sense applied
    always_comb begin
        evt_meta_d = event_i;
        evt_sync_d = evt_meta_q;
        act_d = sense_o ? evt_sync_q : !evt_sync_q; // R01
    end

    // Synchroniser and active-level registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            evt_meta_q <= 1'b0;
            evt_sync_q <= 1'b0;
            act_q <= 1'b0;
        end else if (ce_i) begin
            evt_meta_q <= evt_meta_d;
            evt_sync_q <= evt_sync_d;
            act_q <= act_d;
        end
    end

    assign event_active_o = act_q;
endmodule // esr_top
`default_nettype wire

// [tb/esr_top_checker.sv]
// Checker: register fields, reset values and event sense of esr_top.
// Bound to esr_top; sees its ports only, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module esr_top_checker #(
    parameter logic DEFAULT_SENSE = 1'b1,
    parameter logic [7:0] REV_MAJOR = 8'h01,
    parameter logic [7:0] REV_MINOR = 8'h00,
    parameter logic [15:0] REV_BUILD = 16'h0000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic event_i,
    input wire logic enable_o,
    input wire logic sense_o,
    input wire logic event_active_o
);
    import esr_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Taken requests and the register they hit
    logic wr_tk, rd_rev, wr_sns;
    assign wr_tk = ce_i && s_axi_awready;
    assign rd_rev = ce_i && s_axi_arready && s_axi_araddr == ESR_OFS_REVISION;
    assign wr_sns = wr_tk && s_axi_awaddr == ESR_OFS_SENSE && s_axi_wstrb[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    chk_rev_major:
    assert property (rd_rev |=>
        s_axi_rvalid && s_axi_rdata[31:24] == REV_MAJOR)
        else $error("major field wrong");
    chk_rev_minor:
    assert property (rd_rev |=> s_axi_rdata[23:16] == REV_MINOR)
        else $error("minor field wrong");
    chk_rev_build:
    assert property (rd_rev |=> s_axi_rdata[15:0] == REV_BUILD)
        else $error("build field wrong");
    chk_rev_write_ok:
    assert property (wr_tk && s_axi_awaddr == ESR_OFS_REVISION |=>
        s_axi_bvalid && s_axi_bresp == ESR_RESP_OKAY)
        else $error("revision write reply wrong");
    chk_reset_values:
    assert property ($fell(sys_rst_i) |->
        sense_o == DEFAULT_SENSE && !enable_o)
        else $error("reset value wrong");
    chk_sense_write:
    assert property (wr_sns |=> sense_o == $past(s_axi_wdata[0]))
        else $error("sense write lost");
    chk_sense_keep:
    assert property (!wr_sns |=> $stable(sense_o))
        else $error("sense changed unasked");
    chk_enable_write:
    assert property (wr_tk && s_axi_awaddr == ESR_OFS_CONTROL |=>
        enable_o == $past(s_axi_wdata[0]))
        else $error("enable write lost");
    chk_event_sense:
    assert property ((ce_i && !sys_rst_i)[*3] |=> event_active_o ==
        ($past(sense_o) ? $past(event_i, 3) : !$past(event_i, 3)))
        else $error("event level wrong");
    // Main scenarios
    cover property (wr_sns);
    cover property (rd_rev);
    cover property (s_axi_bvalid && s_axi_bresp == ESR_RESP_DECERR);
endmodule // esr_top_checker
`default_nettype wire

// [tb/esr_top_tb.sv]
// Testbench for esr_top: register table, event sense and reset.
// Assumes esr_pkg and the rtl files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module esr_top_tb;
    import esr_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] r;
        logic [31:0] q;
    } esr_row_s;
    localparam logic [7:0] MAJ = 8'hA5, MNR = 8'h3C;
    localparam logic [15:0] BLD = 16'h1234;
    localparam logic [31:0] REV = {MAJ, MNR, BLD};
    localparam logic [1:0] OK = ESR_RESP_OKAY, DE = ESR_RESP_DECERR;
    localparam logic [31:0] Z = 32'h0000_0000, F = 32'hFFFF_FFFF;
    // Rows: write, address, data, reply code, read data
    localparam esr_row_s ROWS [11] = '{
        '{1'b0, 8'h00, Z, OK, Z}, '{1'b0, 8'h08, Z, OK, Z},
        '{1'b0, 8'h0C, Z, OK, REV}, '{1'b1, 8'h0C, F, OK, Z},
        '{1'b0, 8'h0C, Z, OK, REV}, '{1'b1, 8'h08, F, OK, Z},
        '{1'b0, 8'h08, Z, OK, 32'h0000_0001}, '{1'b1, 8'h00, F, OK, Z},
        '{1'b0, 8'h00, Z, OK, 32'h0000_0001}, '{1'b0, 8'h04, Z, DE, Z},
        '{1'b1, 8'h40, F, DE, Z}};
    logic clk_i = 0, sys_rst_i = 1, ce_i = 1, event_i = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, enable_o, sense_o, event_active_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int miscompares = 0, comparisons = 0;
    esr_top #(.DEFAULT_SENSE(1'b0), .REV_MAJOR(MAJ), .REV_MINOR(MNR),
        .REV_BUILD(BLD)) i_esr_top (.*);
    always #2.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict and bounded wait
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                tally_and_finish();
            end
            @(negedge clk_i);
        end
    endtask
    // One access: request held through the edge that takes it, then
    // ready raised while the reply stands and dropped after its edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(negedge clk_i);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = {w, w, !w};
        {s_axi_awaddr, s_axi_araddr} = {a, a};
        {s_axi_wdata, s_axi_wstrb} = {d, 4'hF};
        #1;
        if (w)
            wait_hi(s_axi_awready);
        else
            wait_hi(s_axi_arready);
        @(posedge clk_i);
        @(negedge clk_i);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b0;
        if (w)
            wait_hi(s_axi_bvalid);
        else
            wait_hi(s_axi_rvalid);
        {s_axi_bready, s_axi_rready} = {w, !w};
        {r, q} = w ? {s_axi_bresp, Z} : {s_axi_rresp, s_axi_rdata};
        @(posedge clk_i);
        @(negedge clk_i);
        {s_axi_bready, s_axi_rready} = 2'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(negedge clk_i);
        sys_rst_i = 0;
        foreach (ROWS[i]) begin
            bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            chk({30'h0, r}, {30'h0, ROWS[i].r});
            if (!ROWS[i].w)
                chk(q, ROWS[i].q);
        end
        // Sense changed only while disabled, event seen through both
        bus(1'b1, ESR_OFS_CONTROL, Z);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, ESR_OFS_SENSE, 32'(s));
            for (int e = 0; e < 2; e++) begin
                event_i = e[0];
                repeat (4) @(negedge clk_i);
                chk(32'(event_active_o), 32'(e == s));
            end
        end
        // Clock enable low freezes the event path at its last level
        ce_i = 0;
        event_i = 0;
        repeat (4) @(negedge clk_i);
        chk(32'(event_active_o), 32'h0000_0001);
        ce_i = 1;
        repeat (4) @(negedge clk_i);
        chk(32'(event_active_o), 32'h0000_0000);
        // Reset in mid-run brings back the build-time sense, disabled
        bus(1'b1, ESR_OFS_CONTROL, 32'h1);
        sys_rst_i = 1;
        repeat (4) @(negedge clk_i);
        sys_rst_i = 0;
        chk({30'h0, enable_o, sense_o}, Z);
        tally_and_finish();
    end
endmodule // esr_top_tb
bind esr_top esr_top_checker #(.DEFAULT_SENSE(DEFAULT_SENSE),
    .REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR), .REV_BUILD(REV_BUILD))
    i_esr_top_checker (.*);
`default_nettype wire
